//--- hw/fsi_pkg.sv
// constants for the framer status and interrupt block
package fsi_pkg;

    // ****************************************************************
    // register map, byte addresses on the bus
    // ****************************************************************
    localparam logic [7:0] FSI_ADR_STATUS = 8'h00;
    localparam logic [7:0] FSI_ADR_MASK = 8'h04;
    localparam logic [7:0] FSI_ADR_ERRCTL = 8'h08;
    localparam logic [7:0] FSI_ADR_GROUP = 8'h0C;
    localparam logic [7:0] FSI_ADR_LIVE = 8'h10;

    // ****************************************************************
    // status and mask field positions
    // ****************************************************************
    localparam int FSI_BIT_LOS = 0;
    localparam int FSI_BIT_LOF = 1;
    localparam int FSI_BIT_AIS = 2;
    localparam int FSI_BIT_RAI = 3;
    localparam int FSI_BIT_IDLE = 4;
    localparam int FSI_BIT_TXSOF = 5;
    localparam int FSI_BIT_RXSOF = 6;
    localparam int FSI_NUM_ALARM = 5;
    localparam int FSI_NUM_STAT = 7;

    // ****************************************************************
    // error insert control and group enable field positions
    // ****************************************************************
    localparam int FSI_NUM_INS = 5;
    localparam int FSI_BIT_FBTYPE_LO = 5;
    localparam int FSI_BIT_MANSEL = 7;
    localparam int FSI_BIT_GROUP = 0;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [6:0] FSI_RST_MASK = 7'h00;
    localparam logic [7:0] FSI_RST_ERRCTL = 8'h00;
    localparam logic FSI_RST_GROUP = 1'b0;

    // ****************************************************************
    // detector counts, in bits, words or frames
    // ****************************************************************
    localparam logic [7:0] FSI_LOS_ZEROS = 8'd192;
    localparam logic [7:0] FSI_LOS_WINDOW = 8'd192;
    localparam logic [2:0] FSI_E3_BAD_FAS = 3'd4;
    localparam logic [1:0] FSI_E3_GOOD_FAS = 2'd3;
    localparam logic [4:0] FSI_T3_F_ERRS = 5'd3;
    localparam logic [4:0] FSI_T3_M_ERRS = 5'd2;
    localparam logic [2:0] FSI_T3_X_FRAMES = 3'd4;

endpackage

//--- hw/fsi_status_irq.sv
// framer alarm status, interrupt gating and error insert trigger
`timescale 1ns/1ps
`default_nettype none

module fsi_status_irq
    import fsi_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // framer mode
    input wire logic e3_mode_i,
    input wire logic cbit_mode_i,
    // receive line bits for loss of signal
    input wire logic rx_bit_en_i,
    input wire logic rx_bit_i,
    input wire logic excess_zero_event_i,
    // e3 frame alignment word checks
    input wire logic fas_check_i,
    input wire logic fas_ok_i,
    // t3 framing bit checks and resync
    input wire logic f_bit_check_i,
    input wire logic f_bit_err_i,
    input wire logic m_bit_check_i,
    input wire logic m_bit_err_i,
    input wire logic t3_sync_i,
    // t3 multiframe x bits
    input wire logic x_bits_check_i,
    input wire logic x1_i,
    input wire logic x2_i,
    // other detector levels
    input wire logic ais_detected_i,
    input wire logic e3_rai_i,
    input wire logic feac_rai_i,
    input wire logic idle_signal_detected_i,
    // frame boundary pulses
    input wire logic tx_frame_start_pin_i,
    input wire logic rx_frame_start_pin_i,
    // manual error trigger
    input wire logic manual_error_input_i,
    // outputs
    output logic [4:0] err_insert_o,
    output logic [1:0] fb_err_type_o,
    output logic [4:0] alarm_o,
    output logic framer_status_group_o
);

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic ack;
        logic [31:0] rdat;
        logic [6:0] stat;
        logic [4:0] chg;
        logic [4:0] cond;
        logic [6:0] mask;
        logic grp;
        logic [7:0] ctl;
        logic [4:0] ctl_prev;
        logic man_prev;
        logic [4:0] ins;
        logic [7:0] zcnt;
        logic win;
        logic [7:0] wcnt;
        logic los;
        logic [2:0] fas_bad;
        logic [1:0] fas_good;
        logic [15:0] fhist;
        logic [3:0] mhist;
        logic lof;
        logic [2:0] xz;
        logic [2:0] xo;
        logic rai_t3;
    } fsi_state_s;

    fsi_state_s q;
    fsi_state_s d;
    logic take;
    logic rd_stat;
    logic wr_take;
    logic [4:0] cond_now;
    logic [6:0] pend;

    // count set bits in a history window
    function automatic logic [4:0] fsi_ones(input logic [15:0] v);
        logic [4:0] n;
        n = 5'd0;
        for (int i = 0; i < 16; i++)
        begin
            n = n + {4'd0, v[i]};
        end
        return n;
    endfunction

    // bus request decode; ack is registered, so one wait state
    assign take = wb_cyc_i && wb_stb_i && !q.ack;
    assign rd_stat = take && !wb_we_i && (wb_adr_i == FSI_ADR_STATUS);
    assign wr_take = take && wb_we_i;

    // live alarm levels; far-end code alarm only counts in c-bit mode
    assign cond_now[FSI_BIT_LOS] = q.los;
    assign cond_now[FSI_BIT_LOF] = q.lof;
    assign cond_now[FSI_BIT_AIS] = ais_detected_i;
    assign cond_now[FSI_BIT_RAI] = e3_mode_i ? e3_rai_i :
        (q.rai_t3 || (cbit_mode_i && feac_rai_i));
    assign cond_now[FSI_BIT_IDLE] = idle_signal_detected_i;

    // pending sources: alarm changes and frame start status bits
    assign pend = {q.stat[FSI_BIT_RXSOF:FSI_BIT_TXSOF], q.chg} & q.mask;
    assign framer_status_group_o = (|pend) && q.grp;

    assign wb_ack_o = q.ack;
    assign wb_dat_o = q.rdat;
    assign err_insert_o = q.ins;
    assign fb_err_type_o = q.ctl[FSI_BIT_FBTYPE_LO+1:FSI_BIT_FBTYPE_LO];
    assign alarm_o = q.cond;

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb
    begin
        d = q;
        d.ack = take;
        d.cond = cond_now;

        // register reads; unmapped addresses answer zero
        if (take && !wb_we_i)
        begin
            unique case (wb_adr_i)
                FSI_ADR_STATUS: d.rdat = {25'd0, q.stat};
                FSI_ADR_MASK: d.rdat = {25'd0, q.mask};
                FSI_ADR_ERRCTL: d.rdat = {24'd0, q.ctl};
                FSI_ADR_GROUP: d.rdat = {31'd0, q.grp};
                FSI_ADR_LIVE: d.rdat = {27'd0, q.cond};
                default: d.rdat = 32'h0000_0000;
            endcase
        end

        // register writes, low byte lane holds every field
        if (wr_take && wb_sel_i[0])
        begin
            unique case (wb_adr_i)
                FSI_ADR_MASK: d.mask = wb_dat_i[6:0];
                FSI_ADR_ERRCTL: d.ctl = wb_dat_i[7:0];
                FSI_ADR_GROUP: d.grp = wb_dat_i[FSI_BIT_GROUP];
                default: d.mask = q.mask;
            endcase
        end

        // status: set wins over the clear of a read
        if (rd_stat)
        begin
            d.stat = 7'h00;
            d.chg = 5'h00;
        end
        d.stat[FSI_NUM_ALARM-1:0] = d.stat[FSI_NUM_ALARM-1:0] | q.cond;
        d.chg = d.chg | (q.cond ^ cond_now);
        d.stat[FSI_BIT_TXSOF] = d.stat[FSI_BIT_TXSOF] || tx_frame_start_pin_i;
        d.stat[FSI_BIT_RXSOF] = d.stat[FSI_BIT_RXSOF] || rx_frame_start_pin_i;

        // error insert triggers; all-zero controls arm nothing
        d.ctl_prev = q.ctl[FSI_NUM_INS-1:0];
        d.man_prev = manual_error_input_i;
        if (q.ctl[FSI_BIT_MANSEL])
        begin
            d.ins = (manual_error_input_i && !q.man_prev) ?
                q.ctl[FSI_NUM_INS-1:0] : 5'h00;
        end
        else
        begin
            d.ins = q.ctl[FSI_NUM_INS-1:0] & ~q.ctl_prev;
        end

        // loss of signal: zero run sets, clean window from a one clears
        if (rx_bit_en_i)
        begin
            if (rx_bit_i)
            begin
                d.zcnt = 8'd0;
            end
            else if (q.zcnt != FSI_LOS_ZEROS)
            begin
                d.zcnt = q.zcnt + 8'd1;
            end
            if (q.los && q.win)
            begin
                if (excess_zero_event_i)
                begin
                    d.win = 1'b0; // wait for the next one to restart
                end
                else if (q.wcnt == FSI_LOS_WINDOW - 8'd1)
                begin
                    d.win = 1'b0;
                    d.los = 1'b0;
                end
                else
                begin
                    d.wcnt = q.wcnt + 8'd1;
                end
            end
            else if (q.los && rx_bit_i)
            begin
                d.win = 1'b1;
                d.wcnt = 8'd1;
            end
            // set after the window, so a new zero run beats a clear
            if (!rx_bit_i && q.zcnt == FSI_LOS_ZEROS - 8'd1)
            begin
                d.los = 1'b1;
            end
        end

        // loss of frame, e3: consecutive bad and good alignment words
        if (e3_mode_i && fas_check_i)
        begin
            if (fas_ok_i)
            begin
                d.fas_bad = 3'd0;
                d.fas_good = q.lof ? q.fas_good + 2'd1 : 2'd0;
                if (q.lof && q.fas_good == FSI_E3_GOOD_FAS - 2'd1)
                begin
                    d.lof = 1'b0;
                    d.fas_good = 2'd0;
                end
            end
            else
            begin
                d.fas_good = 2'd0;
                if (q.fas_bad != FSI_E3_BAD_FAS)
                begin
                    d.fas_bad = q.fas_bad + 3'd1;
                end
                if (q.fas_bad == FSI_E3_BAD_FAS - 3'd1)
                begin
                    d.lof = 1'b1;
                end
            end
        end

        // loss of frame, t3: error density over the last f and m bits
        if (!e3_mode_i)
        begin
            if (f_bit_check_i)
            begin
                d.fhist = {q.fhist[14:0], f_bit_err_i};
            end
            if (m_bit_check_i)
            begin
                d.mhist = {q.mhist[2:0], m_bit_err_i};
            end
            if (t3_sync_i)
            begin
                d.lof = 1'b0;
                d.fhist = 16'h0000;
                d.mhist = 4'h0;
            end
            else if (fsi_ones(d.fhist) >= FSI_T3_F_ERRS ||
                fsi_ones({12'h000, d.mhist}) >= FSI_T3_M_ERRS)
            begin
                d.lof = 1'b1;
            end
        end

        // remote alarm, t3: both x bits agree for four multiframes
        if (!e3_mode_i && x_bits_check_i)
        begin
            d.xz = (!x1_i && !x2_i) ? q.xz + 3'd1 : 3'd0;
            d.xo = (x1_i && x2_i) ? q.xo + 3'd1 : 3'd0;
            if (d.xz == FSI_T3_X_FRAMES)
            begin
                d.rai_t3 = 1'b1;
                d.xz = 3'd0;
            end
            if (d.xo == FSI_T3_X_FRAMES)
            begin
                d.rai_t3 = 1'b0;
                d.xo = 3'd0;
            end
        end
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            q <= '0;
            q.mask <= FSI_RST_MASK;
            q.ctl <= FSI_RST_ERRCTL;
            q.grp <= FSI_RST_GROUP;
        end
        else
        begin
            q <= d;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    property p_los_latch;
        @(posedge clk_i) disable iff (rst_i)
        q.cond[FSI_BIT_LOS] |=> q.stat[FSI_BIT_LOS];
    endproperty
    a_los_latch: assert property (p_los_latch)
        else $error("loss of signal not latched");

    property p_read_clear;
        @(posedge clk_i) disable iff (rst_i)
        (rd_stat && !q.cond[FSI_BIT_AIS]) |=> !q.stat[FSI_BIT_AIS];
    endproperty
    a_read_clear: assert property (p_read_clear)
        else $error("alarm bit not cleared by read");

    property p_txsof;
        @(posedge clk_i) disable iff (rst_i)
        tx_frame_start_pin_i |=> q.stat[FSI_BIT_TXSOF];
    endproperty
    a_txsof: assert property (p_txsof)
        else $error("tx frame start not latched");

    property p_rxsof;
        @(posedge clk_i) disable iff (rst_i)
        rx_frame_start_pin_i |=> q.stat[FSI_BIT_RXSOF];
    endproperty
    a_rxsof: assert property (p_rxsof)
        else $error("rx frame start not latched");

    property p_none_armed;
        @(posedge clk_i) disable iff (rst_i)
        (q.ctl[4:0] == 5'h00) |=> (err_insert_o == 5'h00);
    endproperty
    a_none_armed: assert property (p_none_armed)
        else $error("error inserted with no control bit set");

    property p_manual;
        @(posedge clk_i) disable iff (rst_i)
        (q.ctl[FSI_BIT_MANSEL] && manual_error_input_i && !q.man_prev)
            |=> (err_insert_o == $past(q.ctl[4:0]));
    endproperty
    a_manual: assert property (p_manual)
        else $error("manual trigger did not insert armed errors");

    property p_ctl_rise;
        @(posedge clk_i) disable iff (rst_i)
        (!q.ctl[FSI_BIT_MANSEL] && q.ctl[0] && !q.ctl_prev[0])
            |=> err_insert_o[0];
    endproperty
    a_ctl_rise: assert property (p_ctl_rise)
        else $error("control bit rise did not insert");

    property p_los_count;
        @(posedge clk_i) disable iff (rst_i)
        $rose(q.los) |-> ($past(q.zcnt) == 8'd191) && !$past(rx_bit_i);
    endproperty
    a_los_count: assert property (p_los_count)
        else $error("loss of signal set at wrong zero count");

    property p_e3_lof;
        @(posedge clk_i) disable iff (rst_i)
        (e3_mode_i && fas_check_i && !fas_ok_i && q.fas_bad == 3'd3)
            |=> q.lof;
    endproperty
    a_e3_lof: assert property (p_e3_lof)
        else $error("fourth bad alignment word missed");

    property p_chg_irq;
        @(posedge clk_i) disable iff (rst_i)
        (((q.cond ^ cond_now) & q.mask[4:0]) != 5'h00 && q.grp && !take)
            |=> framer_status_group_o;
    endproperty
    a_chg_irq: assert property (p_chg_irq)
        else $error("alarm change raised no request");

endmodule

`default_nettype wire

//--- sim/fsi_status_irq_test.sv
// self-checking bench for the framer status and interrupt block
`timescale 1ns/1ps
`default_nettype none
module fsi_status_irq_test;
    import fsi_pkg::*;

    // ****************************************************************
    // clock, reset and design ports
    // ****************************************************************
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic e3_mode_i = 1'b0;
    logic cbit_mode_i = 1'b0;
    logic rx_bit_en_i = 1'b0;
    logic rx_bit_i = 1'b0;
    logic excess_zero_i = 1'b0;
    logic fas_check_i = 1'b0;
    logic fas_ok_i = 1'b0;
    logic f_chk_i = 1'b0;
    logic f_err_i = 1'b0;
    logic m_bit_check_i = 1'b0;
    logic m_bit_err_i = 1'b0;
    logic t3_sync_i = 1'b0;
    logic x_bits_check_i = 1'b0;
    logic x1_i = 1'b0;
    logic x2_i = 1'b0;
    logic ais_i = 1'b0;
    logic e3_rai_i = 1'b0;
    logic feac_rai_i = 1'b0;
    logic idle_i = 1'b0;
    logic tx_sof_i = 1'b0;
    logic rx_sof_i = 1'b0;
    logic man_i = 1'b0;
    logic [4:0] err_insert_o;
    logic [1:0] fb_err_type_o;
    logic [4:0] alarm_o;
    logic grp_o;
    int err_total = 0;
    int n_checks = 0;
    int ins_cnt [5] = '{default: 0};

    always #12.5 clk_i = ~clk_i;

    fsi_status_irq dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .e3_mode_i(e3_mode_i),
        .cbit_mode_i(cbit_mode_i), .rx_bit_en_i(rx_bit_en_i),
        .rx_bit_i(rx_bit_i), .excess_zero_event_i(excess_zero_i),
        .fas_check_i(fas_check_i), .fas_ok_i(fas_ok_i),
        .f_bit_check_i(f_chk_i), .f_bit_err_i(f_err_i),
        .m_bit_check_i(m_bit_check_i), .m_bit_err_i(m_bit_err_i),
        .t3_sync_i(t3_sync_i), .x_bits_check_i(x_bits_check_i),
        .x1_i(x1_i), .x2_i(x2_i), .ais_detected_i(ais_i),
        .e3_rai_i(e3_rai_i), .feac_rai_i(feac_rai_i),
        .idle_signal_detected_i(idle_i), .tx_frame_start_pin_i(tx_sof_i),
        .rx_frame_start_pin_i(rx_sof_i), .manual_error_input_i(man_i),
        .err_insert_o(err_insert_o), .fb_err_type_o(fb_err_type_o),
        .alarm_o(alarm_o), .framer_status_group_o(grp_o)
    );

    // count insert pulses so none slips between bus cycles
    always @(posedge clk_i)
        for (int j = 0; j < 5; j++)
            if (err_insert_o[j] === 1'b1)
                ins_cnt[j] <= ins_cnt[j] + 1;

    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic chkb(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // classic single cycle; wait for ack under a bound
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] r);
        int k;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        k = 0;
        do
        begin
            @(posedge clk_i);
            k++;
        end
        while (wb_ack_o !== 1'b1 && k < 20);
        r = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        if (wb_ack_o !== 1'b1)
        begin
            err_total++;
            $display("[ERR] %0t bus timeout", $time);
            results();
        end
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        wb(1'b1, a, d, 4'hF, r);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        wb(1'b0, a, 32'h0, 4'hF, r);
        chk(r, e);
    endtask

    // two reads drop anything latched by earlier traffic
    task automatic flush();
        logic [31:0] r;
        wb(1'b0, FSI_ADR_STATUS, 32'h0, 4'hF, r);
        wb(1'b0, FSI_ADR_STATUS, 32'h0, 4'hF, r);
    endtask

    task automatic set_lvl(input int w, input logic v);
        ais_i <= (w == 0) ? v : 1'b0;
        e3_rai_i <= (w == 1) ? v : 1'b0;
        feac_rai_i <= (w == 2) ? v : 1'b0;
        idle_i <= (w == 3) ? v : 1'b0;
        tick(5);
    endtask

    // strobe one detector input n times, then look at one alarm
    task automatic feed(input int w, input logic v, input int n,
                        input int b, input logic e);
        repeat (n)
        begin
            rx_bit_en_i <= (w == 0);
            fas_check_i <= (w == 1);
            m_bit_check_i <= (w == 2);
            x_bits_check_i <= (w == 3);
            f_chk_i <= (w == 4);
            rx_bit_i <= v;
            fas_ok_i <= v;
            m_bit_err_i <= v;
            x1_i <= v;
            x2_i <= v;
            f_err_i <= v;
            @(posedge clk_i);
        end
        rx_bit_en_i <= 1'b0;
        fas_check_i <= 1'b0;
        m_bit_check_i <= 1'b0;
        x_bits_check_i <= 1'b0;
        f_chk_i <= 1'b0;
        tick(3);
        chkb(alarm_o[b], e);
    endtask

    function automatic logic [31:0] pack_cnt();
        logic [31:0] p;
        p = 32'h0;
        for (int j = 0; j < 5; j++)
            p[j*4 +: 4] = ins_cnt[j][3:0];
        return p;
    endfunction

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic regs_case();
        logic [31:0] r;
        rdc(FSI_ADR_MASK, 32'h0);
        rdc(FSI_ADR_ERRCTL, 32'h0);
        rdc(FSI_ADR_GROUP, 32'h0);
        rdc(8'h40, 32'h0);
        wr(FSI_ADR_MASK, 32'hFF);
        rdc(FSI_ADR_MASK, 32'h7F);
        wb(1'b1, FSI_ADR_MASK, 32'h12, 4'h0, r);
        rdc(FSI_ADR_MASK, 32'h7F);
    endtask

    task automatic alarm_case(input int w, input int b);
        logic [31:0] m;
        m = 32'h1 << b;
        wr(FSI_ADR_MASK, m);
        wr(FSI_ADR_GROUP, 32'h1);
        flush();
        set_lvl(w, 1'b1);
        chkb(grp_o, 1'b1);
        rdc(FSI_ADR_STATUS, m);
        chkb(grp_o, 1'b0);
        rdc(FSI_ADR_STATUS, m);
        set_lvl(w, 1'b0);
        chkb(grp_o, 1'b1);
        rdc(FSI_ADR_STATUS, m);
        rdc(FSI_ADR_STATUS, 32'h0);
        chkb(grp_o, 1'b0);
        wr(FSI_ADR_MASK, 32'h7F & ~m);
        set_lvl(w, 1'b1);
        chkb(grp_o, 1'b0);
        set_lvl(w, 1'b0);
        flush();
    endtask

    task automatic sof_case();
        wr(FSI_ADR_MASK, 32'h60);
        flush();
        for (int i = 0; i < 2; i++)
        begin
            tx_sof_i <= (i == 0);
            rx_sof_i <= (i == 1);
            @(posedge clk_i);
            tx_sof_i <= 1'b0;
            rx_sof_i <= 1'b0;
            tick(3);
            chkb(grp_o, 1'b1);
            rdc(FSI_ADR_STATUS, 32'h20 << i);
            chkb(grp_o, 1'b0);
            rdc(FSI_ADR_STATUS, 32'h0);
        end
        wr(FSI_ADR_GROUP, 32'h0);
        tx_sof_i <= 1'b1;
        @(posedge clk_i);
        tx_sof_i <= 1'b0;
        tick(3);
        chkb(grp_o, 1'b0);
        wr(FSI_ADR_GROUP, 32'h1);
        chkb(grp_o, 1'b1);
        rdc(FSI_ADR_STATUS, 32'h20);
    endtask

    task automatic ins_case();
        logic [31:0] base;
        wr(FSI_ADR_ERRCTL, 32'h60);
        chk({30'h0, fb_err_type_o}, 32'h3);
        for (int i = 0; i < 5; i++)
        begin
            base = pack_cnt();
            wr(FSI_ADR_ERRCTL, 32'h1 << i);
            tick(6);
            wr(FSI_ADR_ERRCTL, 32'h0);
            tick(6);
            chk(pack_cnt() - base, 32'h1 << (4 * i));
        end
        base = pack_cnt();
        wr(FSI_ADR_ERRCTL, 32'h95);
        repeat (2)
        begin
            man_i <= 1'b1;
            tick(4);
            man_i <= 1'b0;
            tick(4);
        end
        chk(pack_cnt() - base, 32'h0002_0202);
        wr(FSI_ADR_ERRCTL, 32'h80);
        base = pack_cnt();
        man_i <= 1'b1;
        tick(4);
        man_i <= 1'b0;
        tick(4);
        chk(pack_cnt() - base, 32'h0);
        wr(FSI_ADR_ERRCTL, 32'h0);
    endtask

    task automatic det_case();
        flush();
        feed(0, 1'b0, 191, 0, 1'b0);
        feed(0, 1'b0, 1, 0, 1'b1);
        rdc(FSI_ADR_STATUS, 32'h1);
        rdc(FSI_ADR_LIVE, 32'h1);
        // an excess zero inside the window restarts it at the next one
        feed(0, 1'b1, 100, 0, 1'b1);
        excess_zero_i <= 1'b1;
        feed(0, 1'b1, 1, 0, 1'b1);
        excess_zero_i <= 1'b0;
        feed(0, 1'b1, 191, 0, 1'b1);
        feed(0, 1'b1, 1, 0, 1'b0);
        flush();
        e3_mode_i <= 1'b1;
        feed(1, 1'b0, 3, 1, 1'b0);
        feed(1, 1'b0, 1, 1, 1'b1);
        rdc(FSI_ADR_STATUS, 32'h2);
        feed(1, 1'b1, 2, 1, 1'b1);
        feed(1, 1'b1, 1, 1, 1'b0);
        e3_mode_i <= 1'b0;
        feed(2, 1'b1, 1, 1, 1'b0);
        feed(2, 1'b1, 1, 1, 1'b1);
        t3_sync_i <= 1'b1;
        @(posedge clk_i);
        t3_sync_i <= 1'b0;
        tick(3);
        chkb(alarm_o[1], 1'b0);
        feed(4, 1'b1, 2, 1, 1'b0);
        feed(4, 1'b1, 1, 1, 1'b1);
        feed(3, 1'b0, 3, 3, 1'b0);
        feed(3, 1'b0, 1, 3, 1'b1);
        feed(3, 1'b1, 3, 3, 1'b1);
        feed(3, 1'b1, 1, 3, 1'b0);
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial
    begin
        tick(3);
        rst_i <= 1'b0;
        tick(1);
        regs_case();
        e3_mode_i <= 1'b1;
        alarm_case(0, 2);
        alarm_case(1, 3);
        alarm_case(3, 4);
        e3_mode_i <= 1'b0;
        cbit_mode_i <= 1'b1;
        alarm_case(2, 3);
        sof_case();
        ins_case();
        det_case();
        results();
    end
endmodule
`default_nettype wire
